//--- verilog/ecm_consts.vh
// Constants for the clock, reset and lane multiplexing block.
`ifndef ECM_CONSTS_VH
`define ECM_CONSTS_VH

// ==========================================================
// Geometry
`define ECM_LANES        10
`define ECM_GT_W         80
`define ECM_PCS_W        32
`define ECM_GRP16_W      16
`define ECM_GRP64_W      64
`define ECM_CLK_IN_TEN   4'hD
`define ECM_CLK_IN_FOUR  4'h7

// ==========================================================
// Lane modes
`define ECM_MODE_TEN     2'h0
`define ECM_MODE_FOUR    2'h1
`define ECM_MODE_SWITCH  2'h2

// ==========================================================
// Line coding
`define ECM_MARKER_TAG   16'hA5C3
`define ECM_MARKER_GAP   8'h3F
`define ECM_SYNC_DATA    2'h1
`define ECM_SYNC_CTRL    2'h2
`define ECM_SCR_SEED     58'h3FFFFFFFFFFFFFF

`endif

//--- verilog/ecm_rst_sync.v
// Reset synchroniser: asynchronous assertion, clocked release.
`timescale 1ns/1ns
module ecm_rst_sync (
  input  wire ref_clk,
  input  wire clk_en,
  input  wire rst_req,
  output reg  rst_out
);
  reg stage;

  // The request reaches both flops at once so assertion needs no clock edge.
  always @(posedge ref_clk or posedge rst_req) begin
    if (rst_req) begin
      stage   <= 1'b1;
      rst_out <= 1'b1;
    end else if (clk_en) begin
      stage   <= 1'b0;
      rst_out <= stage;
    end
  end
endmodule

//--- verilog/ecm_clock_reset_lane_mux.v
// Clocking, reset sequencing and PCS lane multiplexing for the 100G lane block.
`timescale 1ns/1ns
`include "ecm_consts.vh"
module ecm_clock_reset_lane_mux (
  input  wire         ref_clk,
  input  wire         sys_rst,
  input  wire         clk_en,
  input  wire [1:0]   lane_mode,
  input  wire         single_rx_clock,
  input  wire [9:0]   lane_rx_clock,
  input  wire         tx_clock,
  input  wire         rx_clock,
  input  wire         drp_clock,
  input  wire         global_reset,
  input  wire         tx_reset,
  input  wire         rx_reset,
  input  wire [9:0]   lane_rx_reset,
  input  wire         tx_datapath_reset,
  input  wire         rx_datapath_reset,
  input  wire [799:0] gt_rx_data,
  input  wire [19:0]  gt_rx_header,
  input  wire [319:0] tx_pkt_data,
  output wire         tx_pkt_ready,
  output reg  [799:0] gt_tx_data,
  output reg  [19:0]  gt_tx_header,
  output reg  [319:0] pcs_rx_data,
  output reg          pcs_rx_valid,
  output reg          rx_header_error,
  output reg          rx_aligned,
  output reg  [3:0]   clock_input_count,
  output reg          drp_clock_seen,
  output wire         tx_core_reset_out,
  output wire         rx_core_reset_out
);

  // ==========================================================
  // Functions
  // Self-synchronous scrambler, polynomial 1 + x^39 + x^58.
  // Returns the new state above the 32 output bits.
  function [89:0] scr_step;
    input [57:0] s;
    input [31:0] d;
    input        descr;
    reg   [57:0] st;
    reg   [31:0] o;
    integer      k;
    begin
      st = s;
      o  = 32'h0;
      for (k = 0; k < 32; k = k + 1) begin
        o[k] = d[k] ^ st[38] ^ st[57];
        st   = {st[56:0], descr ? d[k] : o[k]};
      end
      scr_step = {st, o};
    end
  endfunction

  // Physical interface feeding a PCS lane; mode aware, the single clock is applied by the caller.
  function [3:0] src_if;
    input [1:0] mode;
    input integer lane;
    integer       quot;
    begin
      quot = lane * 2 / 5;
      if (mode == `ECM_MODE_FOUR) begin
        src_if = quot[3:0];
      end else begin
        src_if = lane[3:0];
      end
    end
  endfunction

  // ==========================================================
  // Pin sampling of the incoming clocks
  wire [12:0] clk_pins = {drp_clock, rx_clock, tx_clock, lane_rx_clock};
  reg  [12:0] pin_s1;
  reg  [12:0] pin_s2;
  reg  [12:0] pin_s3;
  reg  [12:0] pin_filt;
  wire [12:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire [12:0] pin_rise  = pin_agree & pin_s3 & ~pin_filt;

  // Lane clocks are far above ref_clk in silicon; this sampling only tracks
  // slow bench clocks and is meant as an activity and edge qualifier.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1   <= 13'h0000;
      pin_s2   <= 13'h0000;
      pin_s3   <= 13'h0000;
      pin_filt <= 13'h0000;
    end else if (clk_en) begin
      pin_s1   <= clk_pins;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_filt <= (pin_agree & pin_s3) | (~pin_agree & pin_filt);
    end
  end

  wire [9:0] lane_edge = pin_rise[9:0];
  wire       tx_edge   = pin_rise[10];
  wire       rx_edge   = pin_rise[11];

  // ==========================================================
  // Reset synchronisers
  wire tx_core_rst;
  wire tx_lane_rst;
  wire rx_core_rst;
  wire [9:0] rx_lane_rst;
  wire any_global = sys_rst | global_reset;

  ecm_rst_sync u_tx_core (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .rst_req (any_global | tx_reset),
    .rst_out (tx_core_rst)
  );

  ecm_rst_sync u_tx_lane (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .rst_req (any_global | tx_datapath_reset),
    .rst_out (tx_lane_rst)
  );

  ecm_rst_sync u_rx_core (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .rst_req (any_global | rx_reset),
    .rst_out (rx_core_rst)
  );

  assign tx_core_reset_out = tx_core_rst;
  assign rx_core_reset_out = rx_core_rst;

  // ==========================================================
  // Mode capture and clock count
  reg [1:0] mode_q;
  reg       single_q;
  wire      four_mode = (mode_q == `ECM_MODE_FOUR);

  // Mode inputs are only taken while a core reset is held.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q            <= `ECM_MODE_TEN;
      single_q          <= 1'b0;
      clock_input_count <= `ECM_CLK_IN_TEN;
      drp_clock_seen    <= 1'b0;
    end else if (clk_en) begin
      if (tx_core_rst | rx_core_rst) begin
        mode_q   <= lane_mode;
        single_q <= single_rx_clock;
      end
      clock_input_count <= four_mode ? `ECM_CLK_IN_FOUR : `ECM_CLK_IN_TEN;
      drp_clock_seen    <= drp_clock_seen | pin_rise[12];
    end
  end

  // ==========================================================
  // Receive lane logic, one block per PCS lane
  wire [319:0] lane_word_v;
  wire [39:0]  lane_pos_v;
  wire [9:0]   lane_seen_v;
  wire [9:0]   lane_herr_v;

  genvar gi;
  generate
    for (gi = 0; gi < `ECM_LANES; gi = gi + 1) begin : rxl
      wire [3:0]  gif = src_if(mode_q, gi);
      // The receive lane clock is picked by mode, or lane 0 for all lanes.
      wire        strobe = single_q ? lane_edge[0] : lane_edge[gif];
      wire [79:0] gt_word = gt_rx_data[`ECM_GT_W*gif +: `ECM_GT_W];
      wire [15:0] grp16 = gt_rx_data[`ECM_GT_W*(gi*2/5) +: `ECM_GRP16_W];
      wire [63:0] grp64 = gt_rx_data[`ECM_GT_W*(gi*2/5) + `ECM_GRP16_W +: `ECM_GRP64_W];
      wire [79:0] spill = gt_rx_data[`ECM_GT_W*(gi*2/5+1) +: `ECM_GT_W];
      wire [159:0] grp_word = {spill, grp64, grp16};
      wire [31:0] four_word = grp_word[(gi*32) % 80 +: 32];
      wire [31:0] ten_word = gt_word[`ECM_PCS_W-1:0];
      wire [31:0] raw = four_mode ? four_word : ten_word;
      wire [1:0]  hdr = gt_rx_header[2*gi +: 2];
      wire [89:0] dsc;
      reg  [57:0] dstate;
      reg  [31:0] word;
      reg  [3:0]  pos;
      reg         seen;
      reg         herr;

      // Note the split words of four-lane mode straddle interfaces; the lane
      // slices above cover the 320 active bits in order.
      assign dsc = scr_step(dstate, raw, 1'b1);

      always @(posedge ref_clk or posedge rx_lane_rst[gi]) begin
        if (rx_lane_rst[gi]) begin
          dstate <= `ECM_SCR_SEED;
          word   <= 32'h00000000;
          pos    <= 4'h0;
          seen   <= 1'b0;
          herr   <= 1'b0;
        end else if (clk_en && strobe) begin
          if (raw[31:16] == `ECM_MARKER_TAG) begin
            seen <= 1'b1;
            pos  <= raw[3:0];
          end else if (seen) begin
            dstate <= dsc[89:32];
            word   <= dsc[31:0];
            herr   <= (hdr != `ECM_SYNC_DATA) && (hdr != `ECM_SYNC_CTRL);
          end
        end
      end

      ecm_rst_sync u_rx_lane (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .rst_req (any_global | rx_datapath_reset | lane_rx_reset[gi]),
        .rst_out (rx_lane_rst[gi])
      );

      assign lane_word_v[32*gi +: 32] = word;
      assign lane_pos_v[4*gi +: 4]    = pos;
      assign lane_seen_v[gi]          = seen;
      assign lane_herr_v[gi]          = herr;
    end
  endgenerate

  // ==========================================================
  // Receive deskew and lane reorder into the core
  reg [319:0] next_rx_data;
  integer     li;
  integer     lj;

  // Any received lane order is accepted: each word goes to the slot its marker named.
  always @* begin
    next_rx_data = 320'h0;
    for (lj = 0; lj < `ECM_LANES; lj = lj + 1) begin
      for (li = 0; li < `ECM_LANES; li = li + 1) begin
        if (lane_pos_v[4*li +: 4] == lj[3:0]) begin
          next_rx_data[32*lj +: 32] = lane_word_v[32*li +: 32];
        end
      end
    end
  end

  // Lanes are deskewed by releasing all of them together on the core tick,
  // which costs up to one lane word of latency on the early lanes.
  always @(posedge ref_clk or posedge rx_core_rst) begin
    if (rx_core_rst) begin
      pcs_rx_data     <= 320'h0;
      pcs_rx_valid    <= 1'b0;
      rx_header_error <= 1'b0;
      rx_aligned      <= 1'b0;
    end else if (clk_en) begin
      rx_aligned <= &lane_seen_v;
      if (rx_edge) begin
        pcs_rx_valid    <= rx_aligned & (&lane_seen_v);
        rx_header_error <= |lane_herr_v;
        if (rx_aligned & (&lane_seen_v)) begin
          pcs_rx_data <= next_rx_data;
        end
      end
    end
  end

  // ==========================================================
  // Transmit striping, scrambling and lane mapping
  reg  [579:0] tx_state;
  reg  [7:0]   marker_cnt;
  reg  [579:0] next_tx_state;
  reg  [319:0] tx_word;
  reg  [799:0] next_gt_tx;
  reg  [89:0]  tx_scr;
  integer      ti;

  assign tx_pkt_ready = clk_en & tx_edge & ~tx_core_rst & ~tx_lane_rst & (marker_cnt != 8'h00);

  always @* begin
    next_tx_state = tx_state;
    tx_word       = 320'h0;
    next_gt_tx    = 800'h0;
    tx_scr        = 90'h0;
    for (ti = 0; ti < `ECM_LANES; ti = ti + 1) begin
      if (marker_cnt == 8'h00) begin
        tx_word[32*ti +: 32] = {`ECM_MARKER_TAG, 12'h000, ti[3:0]};
      end else begin
        tx_scr = scr_step(tx_state[58*ti +: 58], tx_pkt_data[32*ti +: 32], 1'b0);
        next_tx_state[58*ti +: 58] = tx_scr[89:32];
        tx_word[32*ti +: 32]       = tx_scr[31:0];
      end
      if (!four_mode) begin
        next_gt_tx[`ECM_GT_W*ti +: `ECM_PCS_W] = tx_word[32*ti +: 32];
      end
    end
    if (four_mode) begin
      next_gt_tx[319:0] = tx_word;
    end
  end

  // One tick from the transmit clock updates every lane at once.
  always @(posedge ref_clk or posedge tx_lane_rst) begin
    if (tx_lane_rst) begin
      tx_state     <= {`ECM_LANES{`ECM_SCR_SEED}};
      gt_tx_data   <= 800'h0;
      gt_tx_header <= 20'h00000;
    end else if (clk_en && tx_edge && !tx_core_rst) begin
      tx_state     <= next_tx_state;
      gt_tx_data   <= next_gt_tx;
      gt_tx_header <= (marker_cnt == 8'h00) ? {`ECM_LANES{`ECM_SYNC_CTRL}} :
                                              {`ECM_LANES{`ECM_SYNC_DATA}};
    end
  end

  always @(posedge ref_clk or posedge tx_core_rst) begin
    if (tx_core_rst) begin
      marker_cnt <= 8'h00;
    end else if (clk_en && tx_edge && !tx_lane_rst) begin
      marker_cnt <= (marker_cnt == `ECM_MARKER_GAP) ? 8'h00 : marker_cnt + 8'h01;
    end
  end

endmodule

//--- dv/ecm_properties.sv
// Port-level checks for the clock, reset and lane multiplexing block.
`timescale 1ns/1ns
module ecm_properties (
  input wire         ref_clk,
  input wire         sys_rst,
  input wire [1:0]   lane_mode,
  input wire         global_reset,
  input wire         tx_reset,
  input wire         rx_reset,
  input wire         tx_datapath_reset,
  input wire         tx_pkt_ready,
  input wire [799:0] gt_tx_data,
  input wire [19:0]  gt_tx_header,
  input wire         pcs_rx_valid,
  input wire         rx_aligned,
  input wire [3:0]   clock_input_count,
  input wire         tx_core_reset_out,
  input wire         rx_core_reset_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ========
  // Resets
  tx_hold_a: assert property ((tx_reset || global_reset) |-> tx_core_reset_out)
    else $error("tx core reset not held");
  tx_release_a: assert property ($fell(tx_core_reset_out) |->
    !$past(tx_reset) && !$past(tx_reset, 2) && !$past(global_reset))
    else $error("tx core reset released early");
  rx_indep_a: assert property (!rx_core_reset_out && !rx_reset && !global_reset ##1
    !rx_reset && !global_reset |-> !rx_core_reset_out)
    else $error("rx core reset rose without cause");
  ready_rst_a: assert property (tx_pkt_ready |->
    !tx_core_reset_out && !tx_datapath_reset && !global_reset)
    else $error("tx word taken in reset");
  // ========
  // Transmit lanes, clock count and receive valid
  data_hdr_a: assert property (tx_pkt_ready ##1 !tx_datapath_reset && !global_reset
    |-> gt_tx_header[1:0] == 2'h1)
    else $error("data header wrong");
  tx_marker_a: assert property (gt_tx_header[1:0] == 2'h2 && lane_mode == 2'h0 |->
    gt_tx_data[31:0] == 32'hA5C30000 && gt_tx_data[271:240] == 32'hA5C30003)
    else $error("marker word wrong");
  ten_low_a: assert property (lane_mode == 2'h0 |->
    gt_tx_data[79:32] == 48'h0 && gt_tx_data[719:672] == 48'h0)
    else $error("ten-lane upper bits driven");
  four_pack_a: assert property (lane_mode == 2'h1 |-> gt_tx_data[799:320] == 480'h0)
    else $error("four-lane spill");
  clock_count_a: assert property (!tx_core_reset_out && !rx_core_reset_out |->
    clock_input_count == ((lane_mode == 2'h1) ? 4'h7 : 4'hD))
    else $error("clock input count wrong");
  rx_valid_a: assert property (pcs_rx_valid |-> $past(rx_aligned))
    else $error("rx data before alignment");
endmodule

bind ecm_clock_reset_lane_mux ecm_properties ecm_properties_i (
  .ref_clk, .sys_rst, .lane_mode, .global_reset, .tx_reset, .rx_reset,
  .tx_datapath_reset, .tx_pkt_ready, .gt_tx_data, .gt_tx_header, .pcs_rx_valid,
  .rx_aligned, .clock_input_count, .tx_core_reset_out, .rx_core_reset_out);

//--- dv/ecm_serdes_model.sv
// Transceiver stand-in: link clocks and receive lane words with markers.
`timescale 1ns/1ns
module ecm_serdes_model (
  input  wire         bad_header,
  input  wire         drp_run,
  output reg          link_clk,
  output reg          drp_clock,
  output reg  [799:0] gt_rx_data,
  output reg  [19:0]  gt_rx_header
);
  integer   i;
  reg [5:0] word_num;
  // ========
  // Clocks
  // One link clock feeds lanes, transmit and receive alike.
  initial begin
    link_clk = 1'b0;
    drp_clock = 1'b0;
    gt_rx_data = 800'h0;
    gt_rx_header = 20'h0;
    word_num = 6'h0;
    #7;
    forever #200 link_clk = ~link_clk;
  end
  // The port clock only runs while asked for.
  always #150 drp_clock = drp_run ? ~drp_clock : 1'b0;
  // ========
  // Lane words
  // Words change well clear of the block's delayed edge sampling; lane slots are reversed
  // so that reordering is exercised, and unused upper bits toggle every word.
  // Lane 0 also carries bit 16 set, so that its slot can be told apart after descrambling.
  always @(posedge link_clk) begin
    #50;
    for (i = 0; i < 10; i = i + 1) begin
      gt_rx_data[80*i +: 80] = {~gt_rx_data[80*i+32 +: 48], (word_num == 6'h0) ?
        {16'hA5C3, 12'h000, 4'h9 - i[3:0]} : {15'h0, (i == 0), 10'h0, word_num}};
      gt_rx_header[2*i +: 2] = bad_header ? 2'h3 : ((word_num == 6'h0) ? 2'h2 : 2'h1);
    end
    word_num = word_num + 6'h1;
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the clock, reset and lane multiplexing block.
`timescale 1ns/1ns
module testbench;
  reg          ref_clk, sys_rst, clk_en, single_rx_clock, global_reset, tx_reset;
  reg          rx_reset, tx_datapath_reset, rx_datapath_reset, bad_header, drp_run;
  reg  [1:0]   lane_mode;
  reg  [9:0]   lane_rx_reset;
  reg  [7:0]   rows [0:3];
  wire         link_clk, drp_clock, tx_pkt_ready, pcs_rx_valid, rx_header_error, rx_aligned;
  wire         drp_clock_seen, tx_core_reset_out, rx_core_reset_out;
  wire [799:0] gt_rx_data, gt_tx_data;
  wire [319:0] pcs_rx_data;
  wire [19:0]  gt_rx_header, gt_tx_header;
  wire [3:0]   clock_input_count;
  integer      num_errors, checks_done, r, n, k, seen;

  ecm_serdes_model ecm_serdes_model_i (.bad_header(bad_header), .drp_run(drp_run),
    .link_clk(link_clk), .drp_clock(drp_clock), .gt_rx_data(gt_rx_data),
    .gt_rx_header(gt_rx_header));
  ecm_clock_reset_lane_mux ecm_clock_reset_lane_mux_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .lane_mode(lane_mode), .single_rx_clock(single_rx_clock),
    .lane_rx_clock({10{link_clk}}), .tx_clock(link_clk), .rx_clock(link_clk),
    .drp_clock(drp_clock), .global_reset(global_reset), .tx_reset(tx_reset),
    .rx_reset(rx_reset), .lane_rx_reset(lane_rx_reset), .tx_datapath_reset(tx_datapath_reset),
    .rx_datapath_reset(rx_datapath_reset), .gt_rx_data(gt_rx_data),
    .gt_rx_header(gt_rx_header), .tx_pkt_data({10{32'h5A5A0F0F}}),
    .tx_pkt_ready(tx_pkt_ready), .gt_tx_data(gt_tx_data), .gt_tx_header(gt_tx_header),
    .pcs_rx_data(pcs_rx_data), .pcs_rx_valid(pcs_rx_valid), .rx_header_error(rx_header_error),
    .rx_aligned(rx_aligned), .clock_input_count(clock_input_count),
    .drp_clock_seen(drp_clock_seen), .tx_core_reset_out(tx_core_reset_out),
    .rx_core_reset_out(rx_core_reset_out));

  always #25 ref_clk = ~ref_clk;
  // ========
  // Helpers
  task complete_run;
    begin
      $display("checks_done %0d num_errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  function pick(input [2:0] sel);
    case (sel)
      3'h0: pick = tx_pkt_ready;
      3'h1: pick = rx_aligned;
      3'h2: pick = pcs_rx_valid;
      3'h3: pick = (gt_tx_header[1:0] === 2'h2);
      default: pick = drp_clock_seen;
    endcase
  endfunction
  // Every wait is bounded; running out counts as a mismatch and ends the run.
  task wait_hi(input [2:0] sel);
    begin
      for (k = 0; k < 3000 && pick(sel) !== 1'b1; k = k + 1) begin
        @(posedge ref_clk);
        #1;
      end
      if (k == 3000) begin
        num_errors = num_errors + 1;
        complete_run;
      end
    end
  endtask
  // ========
  // Sequence
  initial begin
    {ref_clk, clk_en, sys_rst, lane_mode, single_rx_clock, bad_header, drp_run} = 8'h60;
    {global_reset, tx_reset, rx_reset, tx_datapath_reset, rx_datapath_reset} = 5'h1F;
    lane_rx_reset = 10'h3FF;
    num_errors = 0;
    checks_done = 0;
    rows[0] = 8'h0D;
    rows[1] = 8'h17;
    rows[2] = 8'h2D;
    rows[3] = 8'h8D;
    repeat (10) @(negedge ref_clk);
    check(clock_input_count, 4'hD);
    check({tx_core_reset_out, rx_core_reset_out, tx_pkt_ready, pcs_rx_valid}, 4'hC);
    sys_rst = 1'b0;
    for (r = 0; r < 4; r = r + 1) begin
      @(negedge ref_clk);
      global_reset = 1'b1;
      lane_mode = rows[r][5:4];
      single_rx_clock = rows[r][7];
      repeat (4) @(negedge ref_clk);
      {global_reset, tx_reset, rx_reset, tx_datapath_reset, rx_datapath_reset} = 5'h0;
      lane_rx_reset = 10'h000;
      wait_hi(3'h0);
      check(clock_input_count, rows[r][3:0]);
      if (rows[r][5:4] != 2'h1) begin
        wait_hi(3'h1);
        wait_hi(3'h2);
        check({rx_aligned, pcs_rx_valid}, 2'h3);
        // Lane 0's extra bit 16 descrambles into bits 10, 16 and 23 once history is full;
        // its marker names slot 9, while lanes 1 and 9 land in slots 8 and 0.
        repeat (32) @(negedge ref_clk);
        check(pcs_rx_data[31:0] ^ pcs_rx_data[287:256], 32'h00000000);
        check(pcs_rx_data[319:288] ^ pcs_rx_data[287:256], 32'h00810400);
      end
    end
    // Sixty-three words pass between two marker ticks.
    wait_hi(3'h3);
    check(gt_tx_data[271:240], 32'hA5C30003);
    n = 0;
    seen = 0;
    for (k = 0; k < 1000 && !(seen == 1 && gt_tx_header[1:0] === 2'h2); k = k + 1) begin
      @(posedge ref_clk);
      #1;
      n = n + tx_pkt_ready;
      if (gt_tx_header[1:0] !== 2'h2)
        seen = 1;
    end
    if (k == 1000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
    check(n, 32'h0000003F);
    @(negedge ref_clk);
    tx_reset = 1'b1;
    @(negedge ref_clk);
    check({tx_core_reset_out, rx_core_reset_out}, 2'h2);
    clk_en = 1'b0;
    tx_reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(tx_core_reset_out, 1'b1);
    clk_en = 1'b1;
    @(negedge ref_clk);
    check(tx_core_reset_out, 1'b1);
    @(negedge ref_clk);
    check(tx_core_reset_out, 1'b0);
    bad_header = 1'b1;
    repeat (40) @(negedge ref_clk);
    check(rx_header_error, 1'b1);
    bad_header = 1'b0;
    lane_rx_reset = 10'h008;
    @(negedge ref_clk);
    check({rx_aligned, rx_core_reset_out, tx_core_reset_out}, 3'h0);
    check(drp_clock_seen, 1'b0);
    drp_run = 1'b1;
    wait_hi(3'h4);
    check(drp_clock_seen, 1'b1);
    @(negedge ref_clk);
    global_reset = 1'b1;
    @(negedge ref_clk);
    check({tx_core_reset_out, rx_core_reset_out}, 2'h3);
    complete_run;
  end
endmodule
